// ===== design/tps_sequencer.sv
// Three-rail power sequencer: ordered release and reverse shutdown of three
// open-drain rail outputs, timed in ticks of the capacitor time base.
// Assumes all inputs are synchronous to core_clk_in; external pull-ups on rails.
// Notes on behaviour
// - Enable high releases rail 1, then rail 2, then rail 3, each after a delay.
// - Enable low shuts down rail 3, then rail 2, then rail 1, each after a delay.
// - Every later step takes exactly eight ticks.
// - A polarity pin inverts the sense of all three rail outputs.
// - Rails are open-drain: drive low or float, never drive high.
// - All delays come from the time base on the timing capacitor pin.
// - Reset pulls all rails low, inactive only with polarity low; after reset, rails stay inactive until enable is first asserted.
// - Enable dropping before rail 1 is released clears the timer, releases nothing.
// - Enable dropping mid power-up shuts released rails down in reverse order.
// - Polarity low means active-high outputs; polarity high means active-low.
`default_nettype none

module tps_sequencer
    import tps_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    // Control pins
    input  wire logic enable_in,
    input  wire logic polarity_select_in,
    input  wire logic timing_cap_pin_in,
    // Rail 1 open-drain pin
    input  wire logic rail_out_1_in,
    output logic      rail_out_1_out,
    output logic      rail_out_1_oe_out,
    // Rail 2 open-drain pin
    input  wire logic rail_out_2_in,
    output logic      rail_out_2_out,
    output logic      rail_out_2_oe_out,
    // Rail 3 open-drain pin
    input  wire logic rail_out_3_in,
    output logic      rail_out_3_out,
    output logic      rail_out_3_oe_out
);

    // ==================================================================
    // State
    tps_state_type                 state_q;
    tps_state_type                 state_d;
    logic [RAIL_COUNT-1:0]         rel_q;
    logic [RAIL_COUNT-1:0]         rel_d;
    logic                          first_q;
    logic                          pol_q;
    logic [RAIL_COUNT-1:0]         oe_q;
    wire  logic                    restart_w;
    wire  logic                    first_d;
    wire  logic                    done_w;
    wire  logic [TICK_CNT_W-1:0]   target_w;
    wire  logic                    going_down_w;
    wire  logic [RAIL_COUNT-1:0]   oe_d;

    function automatic logic is_down(input tps_state_type s);
        is_down = (s == TPS_DN3) || (s == TPS_DN2) || (s == TPS_DN1);
    endfunction

    // ==================================================================
    // Step timer
    assign restart_w    = (state_d != state_q);
    assign going_down_w = is_down(state_d) && !is_down(state_q);
    assign first_d      = restart_w ? ((state_d == TPS_UP1) || going_down_w) : first_q;
    assign target_w     = first_q ? FIRST_STEP_TICKS : NEXT_STEP_TICKS;

    tps_step_timer #(
        .CNT_W      (TICK_CNT_W)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .reset_in   (reset_in),
        .restart_in (restart_w),
        .tick_in    (timing_cap_pin_in),
        .target_in  (target_w),
        .done_out   (done_w)
    );

    // ==================================================================
    // Sequencing
    always_comb
    begin
        state_d = state_q;
        rel_d   = rel_q;
        case (state_q)
            TPS_OFF:
                if (enable_in)
                    state_d = TPS_UP1;
            TPS_UP1:
                if (!enable_in)
                    state_d = TPS_OFF;
                else if (done_w)
                begin
                    state_d  = TPS_UP2;
                    rel_d[0] = 1'b1;
                end
            TPS_UP2:
                if (!enable_in)
                    state_d = TPS_DN1;
                else if (done_w)
                begin
                    state_d  = TPS_UP3;
                    rel_d[1] = 1'b1;
                end
            TPS_UP3:
                if (!enable_in)
                    state_d = TPS_DN2;
                else if (done_w)
                begin
                    state_d  = TPS_ON;
                    rel_d[2] = 1'b1;
                end
            TPS_ON:
                if (!enable_in)
                    state_d = TPS_DN3;
            TPS_DN3:
                if (done_w)
                begin
                    state_d  = TPS_DN2;
                    rel_d[2] = 1'b0;
                end
            TPS_DN2:
                if (done_w)
                begin
                    state_d  = TPS_DN1;
                    rel_d[1] = 1'b0;
                end
            TPS_DN1:
                if (done_w)
                begin
                    state_d  = TPS_OFF;
                    rel_d[0] = 1'b0;
                end
            default:
            begin
                state_d = TPS_OFF;
                rel_d   = RAILS_NONE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_q <= TPS_OFF;
            rel_q   <= RAILS_NONE;
            first_q <= 1'b1;
            pol_q   <= 1'b0;
            oe_q    <= '1;
        end
        else
        begin
            state_q <= state_d;
            rel_q   <= rel_d;
            first_q <= first_d;
            pol_q   <= polarity_select_in;
            oe_q    <= oe_d;
        end
    end

    // ==================================================================
    // Pin drive
    genvar gi;
    generate
        for (gi = 0; gi < RAIL_COUNT; gi++)
        begin : g_rail
            assign oe_d[gi] = ~(rel_d[gi] ^ polarity_select_in);
        end
    endgenerate

    assign rail_out_1_out    = 1'b0;
    assign rail_out_2_out    = 1'b0;
    assign rail_out_3_out    = 1'b0;
    assign rail_out_1_oe_out = oe_q[0];
    assign rail_out_2_oe_out = oe_q[1];
    assign rail_out_3_oe_out = oe_q[2];

    // ==================================================================
    // Checks
    logic [TICK_CNT_W-1:0] chk_cnt_q;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in || restart_w)
            chk_cnt_q <= '0;
        else if (timing_cap_pin_in)
            chk_cnt_q <= chk_cnt_q + 1'b1;
    end

    property p_off_idle;
        @(posedge core_clk_in) disable iff (reset_in)
        (state_q == TPS_OFF) |-> (rel_q == RAILS_NONE);
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("Rail active while off.");

    property p_up_order;
        @(posedge core_clk_in) disable iff (reset_in)
        ($rose(rel_q[1]) |-> rel_q[0]) and ($rose(rel_q[2]) |-> rel_q[1]);
    endproperty
    a_up_order: assert property (p_up_order) else $error("Rails released out of order.");

    property p_down_order;
        @(posedge core_clk_in) disable iff (reset_in)
        ($fell(rel_q[0]) |-> !rel_q[1]) and ($fell(rel_q[1]) |-> !rel_q[2]);
    endproperty
    a_down_order: assert property (p_down_order) else $error("Rails dropped out of order.");

    property p_first_up;
        @(posedge core_clk_in) disable iff (reset_in)
        $rose(rel_q[0]) |-> $past(chk_cnt_q) == FIRST_STEP_TICKS - 4'h1;
    endproperty
    a_first_up: assert property (p_first_up) else $error("First up step wrong length.");

    property p_later_up;
        @(posedge core_clk_in) disable iff (reset_in)
        $rose(rel_q[2]) |-> $past(chk_cnt_q) == NEXT_STEP_TICKS - 4'h1;
    endproperty
    a_later_up: assert property (p_later_up) else $error("Later step wrong length.");

    property p_glitch;
        @(posedge core_clk_in) disable iff (reset_in)
        (state_q == TPS_UP1 && !enable_in) |=> (state_q == TPS_OFF && rel_q == RAILS_NONE);
    endproperty
    a_glitch: assert property (p_glitch) else $error("Enable glitch started a rail.");

    property p_abort;
        @(posedge core_clk_in) disable iff (reset_in)
        (state_q == TPS_UP2 && !enable_in) |=> (state_q == TPS_DN1 && rel_q[0]);
    endproperty
    a_abort: assert property (p_abort) else $error("Aborted power-up not shut down.");

    property p_polarity;
        @(posedge core_clk_in) disable iff (reset_in)
        (pol_q == $past(polarity_select_in)) |->
            (rail_out_1_oe_out == (rel_q[0] == pol_q)) && (rail_out_3_oe_out == (rel_q[2] == pol_q));
    endproperty
    a_polarity: assert property (p_polarity) else $error("Rail drive has wrong sense.");

    property p_open_drain;
        @(posedge core_clk_in) disable iff (reset_in)
        !rail_out_1_out && !rail_out_2_out && !rail_out_3_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("Rail driven high.");

    property p_on_tick;
        @(posedge core_clk_in) disable iff (reset_in)
        (rel_q != $past(rel_q)) |-> $past(timing_cap_pin_in);
    endproperty
    a_on_tick: assert property (p_on_tick) else $error("Rail changed off a tick.");

    c_full_up:   cover property (@(posedge core_clk_in) $rose(rel_q[2]));
    c_full_down: cover property (@(posedge core_clk_in) $fell(rel_q[0]) && state_q == TPS_OFF);
    c_glitch:    cover property (@(posedge core_clk_in) state_q == TPS_UP1 && !enable_in);
    c_abort:     cover property (@(posedge core_clk_in) state_q == TPS_UP3 && !enable_in);
    c_pads_up:   cover property (@(posedge core_clk_in)
        rail_out_1_in && rail_out_2_in && rail_out_3_in);

endmodule // tps_sequencer

`default_nettype wire

// ===== design/tps_pkg.sv
// Shared constants and types of the three-rail power sequencer.
// Assumes a single core clock and a periodic tick from the timing pin.
`default_nettype none

package tps_pkg;

    // ==================================================================
    // Sizes and step lengths
    localparam int unsigned    RAIL_COUNT       = 3;
    localparam int unsigned    TICK_CNT_W       = 4;
    localparam logic [3:0]     FIRST_STEP_TICKS = 4'hA;
    localparam logic [3:0]     NEXT_STEP_TICKS  = 4'h8;
    localparam logic [2:0]     RAILS_NONE       = 3'h0;

    // ==================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        TPS_OFF,
        TPS_UP1,
        TPS_UP2,
        TPS_UP3,
        TPS_ON,
        TPS_DN3,
        TPS_DN2,
        TPS_DN1
    } tps_state_type;

endpackage

`default_nettype wire

// ===== design/tps_step_timer.sv
// Tick counter that times one sequencing step.
// Assumes tick_in is a one-cycle pulse synchronous to core_clk_in.
`default_nettype none

module tps_step_timer
    import tps_pkg::*;
#(
    parameter int unsigned CNT_W = TICK_CNT_W
)
(
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    // Control
    input  wire logic             restart_in,
    input  wire logic             tick_in,
    input  wire logic [CNT_W-1:0] target_in,
    // Status
    output logic                  done_out
);

    // ==================================================================
    // Tick counter
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire  logic       last_tick_w;

    assign last_tick_w = (cnt_q == target_in - {{(CNT_W-1){1'b0}}, 1'b1});
    assign done_out    = tick_in && last_tick_w;
    assign cnt_d       = restart_in ? '0 : (tick_in ? cnt_q + 1'b1 : cnt_q);

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

endmodule // tps_step_timer

`default_nettype wire

// ===== sim/tps_rail_load.sv
// Pull-up load of the three regulator enable pins.
// Assumes oe high means the sequencer pulls the pin low.
`default_nettype none

module tps_rail_load
(
    // Sequencer pin enables
    input  wire logic oe_1_in,
    input  wire logic oe_2_in,
    input  wire logic oe_3_in,
    // Resolved pin levels
    output logic      pad_1_out,
    output logic      pad_2_out,
    output logic      pad_3_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==================================================================
    // Pin levels
    // A released pin floats up to the pull-up level.
    assign pad_1_out = oe_1_in ? 1'h0 : 1'h1;
    assign pad_2_out = oe_2_in ? 1'h0 : 1'h1;
    assign pad_3_out = oe_3_in ? 1'h0 : 1'h1;

endmodule // tps_rail_load

`default_nettype wire

// ===== sim/three_rail_power_sequencer_tb_top.sv
// Self-checking bench of the three-rail power sequencer.
// Assumes the sequencer, its package and the pull-up load model.
`default_nettype none

module three_rail_power_sequencer_tb_top
    import tps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==================================================================
    // Signals
    logic       clk;
    logic       rst;
    logic       en;
    logic       pol;
    logic       tick;
    logic [3:1] oe;
    logic [3:1] dq;
    logic [3:1] pad;
    int         bad_count;
    int         cmp_count;
    int         cyc;
    int         st;
    int         rails;
    int         cnt;
    bit         first;

    tps_sequencer dut (
        .core_clk_in(clk), .reset_in(rst), .enable_in(en), .polarity_select_in(pol),
        .timing_cap_pin_in(tick),
        .rail_out_1_in(pad[1]), .rail_out_1_out(dq[1]), .rail_out_1_oe_out(oe[1]),
        .rail_out_2_in(pad[2]), .rail_out_2_out(dq[2]), .rail_out_2_oe_out(oe[2]),
        .rail_out_3_in(pad[3]), .rail_out_3_out(dq[3]), .rail_out_3_oe_out(oe[3]));

    tps_rail_load load (
        .oe_1_in(oe[1]), .oe_2_in(oe[2]), .oe_3_in(oe[3]),
        .pad_1_out(pad[1]), .pad_2_out(pad[2]), .pad_3_out(pad[3]));

    initial
    begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    // ==================================================================
    // Reference model: state 0 off, 1 rising, 2 on, 3 falling.
    task automatic go(input int s);
        st = s;
        cnt = 0;
        first = 1'b1;
    endtask

    always @(posedge clk)
    begin
        if (rst)
        begin
            go(0);
            rails = 0;
        end
        else if (st == 0 && en)
            go(1);
        else if (st == 1 && !en)
            go(rails == 0 ? 0 : 3);
        else if (st == 2 && !en)
            go(3);
        else if (tick && (st == 1 || st == 3))
        begin
            cnt = cnt + 1;
            if (cnt == (first ? int'(FIRST_STEP_TICKS) : int'(NEXT_STEP_TICKS)))
            begin
                cnt = 0;
                first = 1'b0;
                rails = rails + ((st == 1) ? 1 : -1);
                if (rails == 3)
                    st = 2;
                if (rails == 0)
                    st = 0;
            end
        end
    end

    // ==================================================================
    // Checking and stimulus
    task automatic chk(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic one_tick;
        repeat (3 + $urandom_range(3)) @(posedge clk);
        #1 tick = 1'h1;
        for (int k = 1; k <= 3; k++)
        begin
            chk("rail oe", (rails >= k) ? pol : !pol, oe[k]);
            chk("rail pad", (rails >= k) ? !pol : pol, pad[k]);
            chk("rail data", 1'h0, dq[k]);
        end
        @(posedge clk);
        #1 tick = 1'h0;
    endtask

    task automatic seq(input logic p, input int up_t, input int dn_t);
        pol = p;
        en = 1'h1;
        repeat (up_t) one_tick();
        en = 1'h0;
        repeat (dn_t) one_tick();
        $display("Test done polarity %0d up %0d down %0d", p, up_t, dn_t);
    endtask

    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            $display("Error timeout expected 0 seen %0d", cyc);
            complete_run();
        end
    end

    initial
    begin
        rst = 1'h1;
        en = 1'h0;
        pol = 1'h0;
        tick = 1'h0;
        void'($urandom(63));
        repeat (16) @(posedge clk);
        #1 rst = 1'h0;
        seq(1'h0, 30, 30);
        seq(1'h1, 30, 30);
        seq(1'h0, 9, 30);
        seq(1'h0, 12, 30);
        seq(1'h1, 22, 30);
        seq(1'h0, 40, 12);
        seq(1'h0, 40, 30);
        repeat (4) seq(1'($urandom_range(1)), $urandom_range(1, 40), $urandom_range(27, 40));
        complete_run();
    end

endmodule // three_rail_power_sequencer_tb_top

`default_nettype wire
